//--- rtl/sdd_ctrl.sv
// segment display driver: register slave, segment memory and drive
//
// Contract
// - 8-bit control register with six fields
// - gate bit stops four peripherals in WAIT
// - core timer, first timer, tone generator, display keep running
// - frequency select sets frame divider exponent
// - internal voltage bit enables display and generator
// - extra halve bit halves frame rate
// - multiplex bits choose backplanes and bias
// - external voltage bit connects chain to pin
// - display stays active in WAIT when enabled
// - STOP disables display, outputs discharge
// - display on when either voltage bit set
// - 20-byte segment memory, read and write
// - fixed backplanes, data-built frontplanes each frame
module sdd_ctrl
  import sdd_pkg::*;
#(
  parameter int P_EXP_F00 = SDD_EXP_F00,
  parameter int P_EXP_F10 = SDD_EXP_F10,
  parameter int P_EXP_F01 = SDD_EXP_F01,
  parameter int P_EXP_F11 = SDD_EXP_F11
) (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic        i_wait_mode,
  input  wire logic        i_stop_mode,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_periph_wait_off,
  output logic             o_internal_gen_on,
  output logic             o_external_pin_on,
  output logic             o_display_en,
  output logic [7:0]       o_backplane_lvl,
  output logic [79:0]      o_frontplane_lvl
);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // ---------------------------------------------------------------
  // bus slave: every transfer takes one wait state
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  seg_q [SDD_SEG_BYTES];
  logic        dph_q;
  logic        dwr_q;
  logic        dmap_q;
  logic [7:0]  didx_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        hresp_q;

  logic        accept_w;
  logic        wr_now_w;
  logic        hit_ctrl_w;
  logic        hit_stat_w;
  logic        hit_seg_w;
  logic [4:0]  seg_idx_w;
  logic [7:0]  stat_w;
  logic [31:0] rdata_w;

  // hsize is not decoded: only whole-word single transfers are used
  assign accept_w   = i_hsel && i_htrans[1] && i_hready;
  assign hit_ctrl_w = dmap_q && (didx_q == SDD_CTRL_INDEX);
  assign hit_stat_w = dmap_q && (didx_q == SDD_STAT_INDEX);
  assign hit_seg_w  = dmap_q && (didx_q >= SDD_SEG_FIRST)
                             && (didx_q <= SDD_SEG_LAST);
  assign seg_idx_w  = 5'(didx_q - SDD_SEG_FIRST);
  assign wr_now_w   = dph_q && dwr_q;
  assign rdata_w    = hit_ctrl_w ? {24'h000000, ctrl_q} :
                      hit_stat_w ? {24'h000000, stat_w} :
                      hit_seg_w  ? {24'h000000, seg_q[seg_idx_w]} :
                                   32'h00000000;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dph_q       <= 1'b0;
      dwr_q       <= 1'b0;
      dmap_q      <= 1'b0;
      didx_q      <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h00000000;
      hresp_q     <= 1'b0;
    end else begin
      dph_q       <= accept_w;
      hreadyout_q <= !accept_w;
      if (accept_w) begin
        dwr_q  <= i_hwrite;
        dmap_q <= (i_haddr[31:SDD_INDEX_MSB+1] == '0);
        didx_q <= i_haddr[SDD_INDEX_MSB:SDD_ADDR_LSB];
      end
      if (dph_q) begin
        hrdata_q <= dwr_q ? 32'h00000000 : rdata_w;
      end
    end
  end

  // ---------------------------------------------------------------
  // control register and segment memory
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_q <= SDD_CTRL_RESET;
    end else if (wr_now_w && hit_ctrl_w) begin
      ctrl_q <= i_hwdata[7:0];
    end
  end

  // segment memory keeps its contents through reset, like plain RAM
  always_ff @(posedge i_clock) begin
    if (wr_now_w && hit_seg_w) begin
      seg_q[seg_idx_w] <= i_hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // mode and frame rate decode
  // ---------------------------------------------------------------
  sdd_mode_t    mode_w;
  logic [2:0]   planes_w;
  logic [4:0]   base_exp_w;
  logic [4:0]   shift_w;
  logic         disp_en_w;
  logic [1:0]   slot_w;
  logic         half_w;
  logic [159:0] seg_flat_w;
  logic [7:0]   bp_w;
  logic [79:0]  fp_w;

  assign mode_w = sdd_mode_of({ctrl_q[SDD_MUX_HI_BIT],
                               ctrl_q[SDD_MUX_LO_BIT]});
  assign planes_w = sdd_planes_of(mode_w);

  function automatic logic [4:0] fsel_exp(input logic [1:0] fsel);
    unique case (fsel)
      2'h0: fsel_exp = 5'(P_EXP_F00);
      2'h2: fsel_exp = 5'(P_EXP_F10);
      2'h1: fsel_exp = 5'(P_EXP_F01);
      2'h3: fsel_exp = 5'(P_EXP_F11);
    endcase
  endfunction : fsel_exp

  // a half-slot is the frame over 2*planes; 3 planes run 4/3 faster
  assign base_exp_w = fsel_exp({ctrl_q[SDD_FSEL_HI_BIT],
                                ctrl_q[SDD_FSEL_LO_BIT]});
  assign shift_w    = base_exp_w
                    - ((planes_w == 3'h2) ? SDD_SLOT_SHIFT_2BP
                                          : SDD_SLOT_SHIFT_34BP)
                    + {4'h0, ctrl_q[SDD_HALVE_BIT]};

  // wait is not looked at here, so the display runs through WAIT
  assign disp_en_w = (ctrl_q[SDD_INT_V_BIT] || ctrl_q[SDD_EXT_V_BIT])
                  && !i_stop_mode;
  assign stat_w    = {3'h0, half_w, slot_w, i_stop_mode, o_display_en};

  genvar b;
  generate
    for (b = 0; b < SDD_SEG_BYTES; b++) begin : g_flat
      assign seg_flat_w[b*8 +: 8] = seg_q[b];
    end
  endgenerate

  sdd_frame_gen u_frame (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_run     (disp_en_w),
    .i_shift   (shift_w),
    .i_slots   (planes_w),
    .o_slot    (slot_w),
    .o_half    (half_w),
    .o_tick    ()
  );

  sdd_wave_gen u_wave (
    .i_en      (disp_en_w),
    .i_mode    (mode_w),
    .i_slot    (slot_w),
    .i_half    (half_w),
    .i_seg     (seg_flat_w),
    .o_bp_lvl  (bp_w),
    .o_fp_lvl  (fp_w)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_periph_wait_off <= 1'b0;
      o_internal_gen_on <= 1'b0;
      o_external_pin_on <= 1'b0;
      o_display_en      <= 1'b0;
      o_backplane_lvl   <= 8'h00;
      o_frontplane_lvl  <= 80'h0;
    end else begin
      // only SPI, SCI, second timer and converter are gated; core timer,
      // first timer, tone_melody_generator and display are not
      o_periph_wait_off <= i_wait_mode && ctrl_q[SDD_WAIT_GATE_BIT];
      o_internal_gen_on <= ctrl_q[SDD_INT_V_BIT] && !i_stop_mode;
      o_external_pin_on <= ctrl_q[SDD_EXT_V_BIT];
      o_display_en      <= disp_en_w;
      o_backplane_lvl   <= bp_w;
      o_frontplane_lvl  <= fp_w;
    end
  end

  assign o_hrdata    = hrdata_q;
  assign o_hreadyout = hreadyout_q;
  assign o_hresp     = hresp_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_ctrl_write;
    accept_w && i_hwrite && (i_haddr[31:SDD_INDEX_MSB+1] == '0)
             && (i_haddr[SDD_INDEX_MSB:SDD_ADDR_LSB] == SDD_CTRL_INDEX);
  endsequence

  sequence s_ctrl_read;
    accept_w && !i_hwrite && (i_haddr[31:SDD_INDEX_MSB+1] == '0)
             && (i_haddr[SDD_INDEX_MSB:SDD_ADDR_LSB] == SDD_CTRL_INDEX);
  endsequence

  a_reset_clear: assert property (disable iff (1'b0)
    i_sys_rst |=> (ctrl_q == SDD_CTRL_RESET) && !o_display_en)
    else $error("control register not cleared by reset");

  a_ctrl_write: assert property (
    s_ctrl_write ##1 !hreadyout_q
      |=> (ctrl_q == $past(i_hwdata[7:0])) && hreadyout_q)
    else $error("control write not stored");

  a_ctrl_read: assert property (
    s_ctrl_read ##1 $stable(ctrl_q)
      |=> o_hreadyout && (o_hrdata == {24'h000000, $past(ctrl_q)}))
    else $error("control read data wrong");

  a_wait_gate: assert property (
    (i_wait_mode && ctrl_q[SDD_WAIT_GATE_BIT]) |=> o_periph_wait_off)
    else $error("peripherals not gated in wait");

  a_wait_display: assert property (
    (i_wait_mode && !i_stop_mode && ctrl_q[SDD_EXT_V_BIT])
      |=> o_display_en)
    else $error("display dropped in wait");

  a_stop_off: assert property (
    i_stop_mode |=> !o_display_en && !o_internal_gen_on
                    && (o_backplane_lvl == 8'h00)
                    && (o_frontplane_lvl == 80'h0))
    else $error("display still driven in stop");

  a_enable_bits: assert property (
    o_display_en |-> $past(ctrl_q[SDD_INT_V_BIT] || ctrl_q[SDD_EXT_V_BIT]))
    else $error("display on with both voltage bits clear");

  a_unused_planes: assert property (
    (disp_en_w && (planes_w == 3'h2)) |=> (o_backplane_lvl[7:4] == 4'h0))
    else $error("unused backplanes driven in two-plane mode");

  a_halve_shift: assert property (
    (ctrl_q[SDD_HALVE_BIT] && $stable(ctrl_q))
      |-> (shift_w == base_exp_w + 5'h01
                      - ((planes_w == 3'h2) ? SDD_SLOT_SHIFT_2BP
                                            : SDD_SLOT_SHIFT_34BP)))
    else $error("extra halve not applied");

  a_segment_on: assert property (
    (disp_en_w && !half_w && seg_flat_w[slot_w])
      |=> (o_frontplane_lvl[1:0] == SDD_LVL_V0)
          && (o_backplane_lvl[2*$past(slot_w) +: 2] == SDD_LVL_V3))
    else $error("active segment not driven full scale");

  a_wait_no_gate: assert property (
    !ctrl_q[SDD_WAIT_GATE_BIT] |=> !o_periph_wait_off)
    else $error("peripherals gated with gate bit clear");

  a_int_gen: assert property (
    (ctrl_q[SDD_INT_V_BIT] && !i_stop_mode) |=> o_internal_gen_on)
    else $error("internal generator not on");

  a_ext_pin: assert property (
    o_external_pin_on == $past(ctrl_q[SDD_EXT_V_BIT]))
    else $error("external pin does not follow its bit");

  a_seg_write: assert property (
    (wr_now_w && hit_seg_w)
      |=> (seg_q[$past(seg_idx_w)] == $past(i_hwdata[7:0])))
    else $error("segment byte not stored");

endmodule : sdd_ctrl

//--- rtl/sdd_frame_gen.sv
// frame divider: half-slot ticks and slot/half phase of the frame
module sdd_frame_gen
  import sdd_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_run,
  input  wire logic [4:0] i_shift,
  input  wire logic [2:0] i_slots,
  output logic [1:0]      o_slot,
  output logic            o_half,
  output logic            o_tick
);

  logic [SDD_CNT_W-1:0] cnt_q;
  logic [SDD_CNT_W-1:0] cnt_d;
  logic [SDD_CNT_W-1:0] limit_w;
  logic [1:0]           slot_q;
  logic [1:0]           slot_d;
  logic                 half_q;
  logic                 last_slot_w;
  logic                 wrap_w;

  // ---------------------------------------------------------------
  // divider; >= so a smaller shift never strands the count
  // ---------------------------------------------------------------
  assign limit_w     = (SDD_CNT_W'(1) << i_shift) - SDD_CNT_W'(1);
  assign o_tick      = i_run && (cnt_q >= limit_w);
  assign cnt_d       = o_tick ? '0 : cnt_q + SDD_CNT_W'(1);
  assign last_slot_w = ({1'b0, slot_q} + 3'h1) >= i_slots;
  assign wrap_w      = o_tick && half_q && last_slot_w;
  assign slot_d      = !half_q ? slot_q : (last_slot_w ? 2'h0 : slot_q + 2'h1);
  assign o_slot      = slot_q;
  assign o_half      = half_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !i_run) begin
      cnt_q  <= '0;
      slot_q <= 2'h0;
      half_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (o_tick) begin
        half_q <= !half_q;
        slot_q <= slot_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // frame length check: 2 * slots half-slots of 2^shift cycles
  // ---------------------------------------------------------------
  logic [SDD_CNT_W+2:0] frame_cnt_q;
  logic                 settled_q;
  logic [SDD_CNT_W+2:0] frame_len_w;
  logic [4:0]           shift_q;
  logic [2:0]           slots_q;
  logic                 chg_w;

  assign frame_len_w = ((SDD_CNT_W + 3)'(i_slots) << 1) << i_shift;
  assign chg_w       = (i_shift != shift_q) || (i_slots != slots_q);

  // last setting seen, so a change restarts the length check
  always_ff @(posedge i_clock) begin
    shift_q <= i_shift;
    slots_q <= i_slots;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !i_run || chg_w) begin
      frame_cnt_q <= '0;
      settled_q   <= 1'b0;
    end else if (wrap_w) begin
      frame_cnt_q <= '0;
      settled_q   <= 1'b1;
    end else begin
      frame_cnt_q <= frame_cnt_q + (SDD_CNT_W + 3)'(1);
    end
  end

  a_frame_length: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (wrap_w && settled_q && $stable(i_shift) && $stable(i_slots))
      |-> (frame_cnt_q + (SDD_CNT_W + 3)'(1)) == frame_len_w)
    else $error("frame length does not match divider setting");

endmodule : sdd_frame_gen

//--- rtl/sdd_pkg.sv
// constants, types and decode functions for the segment display driver
package sdd_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] SDD_CTRL_INDEX  = 8'h1E;
  localparam logic [7:0] SDD_STAT_INDEX  = 8'h1F;
  localparam logic [7:0] SDD_SEG_FIRST   = 8'h54;
  localparam logic [7:0] SDD_SEG_LAST    = 8'h67;
  localparam int         SDD_SEG_BYTES   = 20;
  localparam int         SDD_FP_COUNT    = 40;
  localparam int         SDD_BP_COUNT    = 4;
  localparam int         SDD_ADDR_LSB    = 2;
  localparam int         SDD_INDEX_MSB   = 9;

  // ---------------------------------------------------------------
  // control register fields and reset value
  // ---------------------------------------------------------------
  localparam int         SDD_WAIT_GATE_BIT = 7;
  localparam int         SDD_FSEL_HI_BIT   = 6;
  localparam int         SDD_FSEL_LO_BIT   = 5;
  localparam int         SDD_INT_V_BIT     = 4;
  localparam int         SDD_HALVE_BIT     = 3;
  localparam int         SDD_MUX_HI_BIT    = 2;
  localparam int         SDD_MUX_LO_BIT    = 1;
  localparam int         SDD_EXT_V_BIT     = 0;
  localparam logic [7:0] SDD_CTRL_RESET    = 8'h00;

  // ---------------------------------------------------------------
  // frame divider exponents per frequency select code
  // ---------------------------------------------------------------
  localparam int         SDD_EXP_F00 = 16;
  localparam int         SDD_EXP_F10 = 15;
  localparam int         SDD_EXP_F01 = 14;
  localparam int         SDD_EXP_F11 = 9;
  localparam logic [4:0] SDD_SLOT_SHIFT_2BP  = 5'h02;
  localparam logic [4:0] SDD_SLOT_SHIFT_34BP = 5'h03;
  localparam int         SDD_CNT_W = 18;

  // ---------------------------------------------------------------
  // drive level codes, V0 lowest to V3 highest
  // ---------------------------------------------------------------
  localparam logic [1:0] SDD_LVL_V0 = 2'h0;
  localparam logic [1:0] SDD_LVL_V1 = 2'h1;
  localparam logic [1:0] SDD_LVL_V2 = 2'h2;
  localparam logic [1:0] SDD_LVL_V3 = 2'h3;

  typedef enum logic [1:0] {
    SDD_MODE_2BP_HALF,
    SDD_MODE_3BP,
    SDD_MODE_4BP,
    SDD_MODE_2BP_THIRD
  } sdd_mode_t;

  function automatic sdd_mode_t sdd_mode_of(input logic [1:0] mux);
    unique case (mux)
      2'h0: sdd_mode_of = SDD_MODE_2BP_HALF;
      2'h1: sdd_mode_of = SDD_MODE_3BP;
      2'h2: sdd_mode_of = SDD_MODE_4BP;
      2'h3: sdd_mode_of = SDD_MODE_2BP_THIRD;
    endcase
  endfunction : sdd_mode_of

  function automatic logic [2:0] sdd_planes_of(input sdd_mode_t mode);
    unique case (mode)
      SDD_MODE_3BP: sdd_planes_of = 3'h3;
      SDD_MODE_4BP: sdd_planes_of = 3'h4;
      default:      sdd_planes_of = 3'h2;
    endcase
  endfunction : sdd_planes_of

endpackage : sdd_pkg

//--- rtl/sdd_wave_gen.sv
// backplane and frontplane drive levels for the current frame phase
module sdd_wave_gen
  import sdd_pkg::*;
(
  input  wire logic        i_en,
  input  wire sdd_mode_t   i_mode,
  input  wire logic [1:0]  i_slot,
  input  wire logic        i_half,
  input  wire logic [159:0] i_seg,
  output logic [7:0]       o_bp_lvl,
  output logic [79:0]      o_fp_lvl
);

  logic       third_w;
  logic [2:0] planes_w;

  assign third_w  = (i_mode != SDD_MODE_2BP_HALF);
  assign planes_w = sdd_planes_of(i_mode);

  // selected plane swings full scale, polarity flips each half
  function automatic logic [1:0] swing(input logic half);
    swing = half ? SDD_LVL_V0 : SDD_LVL_V3;
  endfunction : swing

  // ---------------------------------------------------------------
  // backplanes: fixed per mode, never looks at segment data
  // ---------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < SDD_BP_COUNT; k++) begin : g_bp
      assign o_bp_lvl[2*k +: 2] =
        (!i_en || (3'(k) >= planes_w)) ? SDD_LVL_V0 :
        (i_slot == 2'(k))              ? swing(i_half) :
        (third_w && i_half)            ? SDD_LVL_V2 : SDD_LVL_V1;
    end
  endgenerate

  // ---------------------------------------------------------------
  // frontplanes: 'on' opposes the selected backplane for full drive
  // ---------------------------------------------------------------
  genvar j;
  generate
    for (j = 0; j < SDD_FP_COUNT; j++) begin : g_fp
      logic on_w;
      assign on_w = i_seg[(j/2)*8 + (j%2)*4 + int'(i_slot)];
      assign o_fp_lvl[2*j +: 2] =
        !i_en   ? SDD_LVL_V0 :
        on_w    ? swing(!i_half) :
        third_w ? (i_half ? SDD_LVL_V1 : SDD_LVL_V2) : swing(i_half);
    end
  endgenerate

endmodule : sdd_wave_gen

//--- tb/sdd_glass_model.sv
// display glass model: which backplanes drove segment 0 fully last frame
module sdd_glass_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_bp_lvl,
  input  wire logic [1:0] i_fp_lvl,
  output logic [3:0]      o_lit
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] acc_q;
  logic [3:0] hit;
  logic [3:0] sel;
  logic [3:0] sel_q;
  logic [1:0] bp0_q;
  logic       start;

  // ---------------------------------------------------------------
  // full swing (V3 against V0) is the only drive that lights a cell
  // ---------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      hit[k] = ({i_bp_lvl[2*k +: 2], i_fp_lvl} == 4'hC) ||
               ({i_bp_lvl[2*k +: 2], i_fp_lvl} == 4'h3);
      sel[k] = (i_bp_lvl[2*k +: 2] == 2'h3);
    end
  end
  assign start = (i_bp_lvl[1:0] == 2'h3) && (bp0_q != 2'h3);

  always_ff @(posedge i_clock) begin
    bp0_q <= i_bp_lvl[1:0];
    // a plane never selected in the frame has no glass wired to it
    if (start) begin
      o_lit <= acc_q & sel_q;
      acc_q <= hit;
      sel_q <= sel;
    end else begin
      acc_q <= acc_q | hit;
      sel_q <= sel_q | sel;
    end
  end
endmodule : sdd_glass_model

//--- tb/tb.sv
// self-checking testbench for the segment display driver control block
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end

module tb;
  import sdd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // shortened divider exponents keep frames to at most 128 clocks
  // ---------------------------------------------------------------
  localparam int E00 = 6;
  localparam int E10 = 5;
  localparam int E01 = 4;
  localparam int E11 = 3;

  logic        clk, rst, hsel, hwrite, wmode, smode, hrdy, hresp;
  logic        pwoff, igen, xpin, den;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [7:0]  bp, c;
  logic [79:0] fp;
  logic [3:0]  lit, seen;
  logic [7:0]  mem [20];
  int          miscompares, tests_run, len;

  sdd_ctrl #(.P_EXP_F00(E00), .P_EXP_F10(E10), .P_EXP_F01(E01),
    .P_EXP_F11(E11)) dut (
    .i_clock(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .i_wait_mode(wmode),
    .i_stop_mode(smode), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_periph_wait_off(pwoff),
    .o_internal_gen_on(igen), .o_external_pin_on(xpin),
    .o_display_en(den), .o_backplane_lvl(bp), .o_frontplane_lvl(fp));

  sdd_glass_model glass (.i_clock(clk), .i_bp_lvl(bp),
    .i_fp_lvl(fp[1:0]), .o_lit(lit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic int flen(input int f, input int m, input int h);
    int e;
    e = (f == 0) ? E00 : (f == 2) ? E10 : (f == 1) ? E01 : E11;
    return (m == 1) ? 3 * (1 << (e + h - 2)) : 1 << (e + h);
  endfunction : flen

  function automatic logic [3:0] pmask(input int m);
    return (m == 1) ? 4'h7 : (m == 2) ? 4'hF : 4'h3;
  endfunction : pmask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // single word transfer; called right after a rising edge
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
  endtask : bus

  // runs to the next frame start, noting which backplanes were selected
  task automatic frame();
    logic [1:0] prev;
    len = 0;
    seen = 4'h0;
    do begin
      prev = bp[1:0];
      @(posedge clk);
      len++;
      for (int k = 0; k < 4; k++) begin
        if (bp[2*k +: 2] === 2'h3) seen[k] = 1'b1;
      end
    end while (!(bp[1:0] === 2'h3 && prev !== 2'h3) && len < 2000);
    if (len >= 2000) begin
      miscompares++;
      test_done();
    end
  endtask : frame

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wmode = 1'b0;
    smode = 1'b0;
    seed = 32'hAB0C;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("pins", 4'h0, {pwoff, igen, xpin, den})
    bus(1'b0, 32'h78, 32'h0);
    `CHK("ctrl reset", 32'h0, r)
    bus(1'b0, 32'h7C, 32'h0);
    `CHK("status", 32'h0, r)
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      c = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      bus(1'b1, 32'h78, {24'h0, c});
      wmode <= seed[8];
      smode <= seed[9];
      bus(1'b0, 32'h78, 32'h0);
      `CHK("ctrl", {24'h0, c}, r)
      `CHK("wait off", seed[8] & c[7], pwoff)
      `CHK("int gen", c[4] & ~seed[9], igen)
      `CHK("ext pin", c[0], xpin)
      `CHK("disp en", (c[4] | c[0]) & ~seed[9], den)
      if (((c[4] | c[0]) & ~seed[9]) == 1'b0) begin
        `CHK("bp idle", 8'h0, bp)
        `CHK("fp idle", 80'h0, fp)
      end
    end
    smode <= 1'b0;
    // unmapped places: writes vanish, reads give zero
    bus(1'b1, 32'h200, 32'hFF);
    bus(1'b0, 32'h200, 32'h0);
    `CHK("unmapped", 32'h0, r)
    bus(1'b0, 32'h1A0, 32'h0);
    `CHK("past seg", 32'h0, r)
    for (int b = 0; b < 20; b++) begin
      seed = xs(seed);
      mem[b] = seed[7:0];
      bus(1'b1, (32'(SDD_SEG_FIRST) + b) * 4, {24'h0, mem[b]});
    end
    for (int b = 0; b < 20; b++) begin
      bus(1'b0, (32'(SDD_SEG_FIRST) + b) * 4, 32'h0);
      `CHK("seg mem", {24'h0, mem[b]}, r)
    end
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 4; f++) begin
        for (int h = 0; h < 2; h++) begin
          seed = xs(seed);
          c = {1'b0, f[1:0], 1'b0, h[0], m[1:0], 1'b0};
          bus(1'b1, 32'h78, {24'h0, c});
          bus(1'b1, 32'h78, {24'h0, c | 8'h10});
          wmode <= seed[0];
          frame();
          frame();
          frame();
          `CHK("frame len", 32'(flen(f, m, h)), 32'(len))
          `CHK("planes", pmask(m), seen)
          `CHK("glass", pmask(m) & mem[0][3:0], lit)
        end
      end
    end
    test_done();
  end
endmodule : tb
